// *** design/udr_regs.sv ***
`timescale 1ns/1ps
module udr_regs
  import udr_pkg::*;
#(
  parameter int DEPTH = udr_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // multiplexed host bus
  input  wire logic [7:0] ad_i,
  output logic      [7:0] ad_o,
  output logic            ad_oe_o,
  input  wire logic       cs_n_i,
  input  wire logic       address_latch_n_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  // serial pins
  input  wire logic       serial_in_a_i,
  input  wire logic       serial_in_b_i,
  output logic            serial_out_a_o,
  output logic            serial_out_b_o,
  // queue status pins
  output logic            rx_avail_n_a_o,
  output logic            rx_avail_n_b_o,
  output logic            tx_space_n_a_o,
  output logic            tx_space_n_b_o,
  // uart core, transmit side (index 0 = channel a)
  output logic      [7:0] tx_byte_a_o,
  output logic      [7:0] tx_byte_b_o,
  output logic      [1:0] tx_byte_valid_o,
  input  wire logic [1:0] tx_byte_take_i,
  input  wire logic [1:0] core_tx_i,
  // uart core, receive side
  input  wire logic [7:0] rx_byte_a_i,
  input  wire logic [7:0] rx_byte_b_i,
  input  wire logic [1:0] rx_byte_valid_i,
  output logic      [1:0] rx_room_o,
  output logic      [1:0] core_rx_o,
  // settings for the uart core
  output logic      [1:0] extended_o,
  output logic      [7:0] line_control_a_o,
  output logic      [7:0] line_control_b_o
);
  import udr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [7:0] FULL = 8'(DEPTH);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic udr_sel_t decode(input logic [2:0] idx, input logic [7:0] line_control,
                                      input logic [7:0] extra_feature_control, input logic rd);
    udr_sel_t s;
    s = SEL_NONE;
    if (line_control == LCR_ENHANCED_KEY && (idx == IDX_2 || idx >= IDX_4))
    begin
      case (idx)
        IDX_2:   s = SEL_EFR;
        IDX_4:   s = SEL_RESUME_CHAR_1;
        IDX_5:   s = SEL_RESUME_CHAR_2;
        IDX_6:   s = SEL_PAUSE_CHAR_1;
        default: s = SEL_PAUSE_CHAR_2;
      endcase
    end
    else if (line_control[LCR_BANK_BIT] && idx <= IDX_1)
    begin
      s = (idx == IDX_0) ? SEL_DLL : SEL_DLM;
    end
    else if (extra_feature_control[EXTRA_FEATURE_CONTROL_COUNT_BIT] && (idx == IDX_3 || idx == IDX_4) && rd)
    begin
      s = (idx == IDX_3) ? SEL_TXCNT : SEL_RXCNT;
    end
    else if (extra_feature_control[EXTRA_FEATURE_CONTROL_COUNT_BIT] && idx == IDX_4)
    begin
      s = SEL_NONE;
    end
    else if (extra_feature_control[2:1] == EXTRA_FEATURE_CONTROL_BANK_LEVEL && (idx == IDX_2 || idx == IDX_4 || idx >= IDX_6))
    begin
      case (idx)
        IDX_2:   s = SEL_TXLVL;
        IDX_4:   s = SEL_RXLVL;
        IDX_6:   s = SEL_FLH;
        default: s = SEL_FLL;
      endcase
    end
    else if (extra_feature_control[2:1] == EXTRA_FEATURE_CONTROL_BANK_PRESC && (idx == IDX_2 || idx == IDX_4 || idx >= IDX_6))
    begin
      case (idx)
        IDX_2:   s = SEL_PRESC;
        IDX_4:   s = SEL_TURN;
        IDX_6:   s = SEL_AF2;
        default: s = SEL_AF1;
      endcase
    end
    else if (!line_control[LCR_BANK_BIT] || idx >= IDX_2)
    begin
      case (idx)
        IDX_0:   s = SEL_DATA;
        IDX_1:   s = SEL_IER;
        IDX_2:   s = SEL_ISR_FCR;
        IDX_3:   s = SEL_LCR;
        IDX_4:   s = SEL_MCR;
        IDX_5:   s = SEL_LSR_EXTRA_FEATURE_CONTROL;
        IDX_6:   s = rd ? SEL_MSR : SEL_NONE;
        default: s = SEL_SPR;
      endcase
    end
    return s;
  endfunction : decode

  function automatic logic [7:0] rx_trigger(input logic [1:0] code);
    case (code)
      2'h0:    return RX_TRIG_0;
      2'h1:    return RX_TRIG_1;
      2'h2:    return RX_TRIG_2;
      default: return RX_TRIG_3;
    endcase
  endfunction : rx_trigger

  // ************************************************************
  // bus pin synchronisers
  // ************************************************************
  logic [7:0] ad_s1_r;
  logic [7:0] ad_s2_r;
  logic [3:0] ctl_s1_r;
  logic [3:0] ctl_s2_r;
  logic       rd_prev_r;
  logic       wr_prev_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ad_s1_r  <= 8'h00;
      ad_s2_r  <= 8'h00;
      ctl_s1_r <= 4'hf;
      ctl_s2_r <= 4'hf;
    end
    else
    begin
      ad_s1_r  <= ad_i;
      ad_s2_r  <= ad_s1_r;
      ctl_s1_r <= {cs_n_i, address_latch_n_i, read_strobe_n_i, write_strobe_n_i};
      ctl_s2_r <= ctl_s1_r;
    end
  end

  logic cs_s;
  logic lla_s;
  logic rd_s;
  logic wr_s;
  assign {cs_s, lla_s, rd_s, wr_s} = ctl_s2_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
    end
    else
    begin
      rd_prev_r <= rd_s;
      wr_prev_r <= wr_s;
    end
  end

  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  assign rd_fall = rd_prev_r & ~rd_s;
  assign rd_rise = ~rd_prev_r & rd_s;
  assign wr_fall = wr_prev_r & ~wr_s;
  assign wr_rise = ~wr_prev_r & wr_s;

  // ************************************************************
  // address phase and access capture
  // ************************************************************
  logic [7:0] addr_r;
  logic       hit_r;
  logic       chan_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      addr_r <= 8'h00;
    end
    else if (!lla_s)
    begin
      addr_r <= ad_s2_r;
    end
  end

  // select is frozen at the strobe's fall so a late chip select edge cannot split an access
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      hit_r  <= 1'b0;
      chan_r <= 1'b0;
    end
    else if (rd_fall || wr_fall)
    begin
      hit_r  <= ~cs_s & ~addr_r[ADDR_HIGH_BIT];
      chan_r <= addr_r[ADDR_CHAN_BIT];
    end
  end

  // ************************************************************
  // per-channel registers
  // ************************************************************
  logic [7:0] ier_r [2];
  logic [7:0] fcr_r [2];
  logic [7:0] lcr_r [2];
  logic [7:0] mcr_r [2];
  logic [7:0] extra_feature_control_r [2];
  logic [7:0] spr_r [2];
  logic [7:0] dll_r [2];
  logic [7:0] dlm_r [2];
  logic [7:0] efr_r [2];
  logic [7:0] resume_char_1_r [2];
  logic [7:0] resume_char_2_r [2];
  logic [7:0] pause_char_1_r [2];
  logic [7:0] pause_char_2_r [2];
  logic [7:0] txlvl_r [2];
  logic [7:0] rxlvl_r [2];
  logic [7:0] flh_r [2];
  logic [7:0] fll_r [2];
  logic [7:0] presc_r [2];
  logic [7:0] turn_r [2];
  logic [7:0] af2_r [2];
  logic [7:0] af1_r [2];
  udr_sel_t   wsel [2];
  udr_sel_t   rsel [2];
  logic [1:0] wr_go;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      wsel[c]  = decode(addr_r[3:1], lcr_r[c], extra_feature_control_r[c], 1'b0);
      rsel[c]  = decode(addr_r[3:1], lcr_r[c], extra_feature_control_r[c], 1'b1);
      wr_go[c] = wr_rise & hit_r & (chan_r == 1'(c));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        ier_r[c]  <= REG_RESET; fcr_r[c]   <= REG_RESET; lcr_r[c]   <= REG_RESET;
        mcr_r[c]  <= REG_RESET; extra_feature_control_r[c]  <= REG_RESET; spr_r[c]   <= REG_RESET;
        dll_r[c]  <= REG_RESET; dlm_r[c]   <= REG_RESET; efr_r[c]   <= REG_RESET;
        resume_char_1_r[c] <= REG_RESET; resume_char_2_r[c]  <= REG_RESET; pause_char_1_r[c] <= REG_RESET;
        pause_char_2_r[c] <= REG_RESET; txlvl_r[c] <= REG_RESET; rxlvl_r[c] <= REG_RESET;
        flh_r[c]  <= REG_RESET; fll_r[c]   <= REG_RESET; presc_r[c] <= REG_RESET;
        turn_r[c] <= REG_RESET; af2_r[c]   <= REG_RESET; af1_r[c]   <= REG_RESET;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wr_go[c])
        begin
          case (wsel[c])
            SEL_IER:      ier_r[c]   <= ad_s2_r;
            SEL_ISR_FCR:  fcr_r[c]   <= ad_s2_r;
            SEL_LCR:      lcr_r[c]   <= ad_s2_r;
            SEL_MCR:      mcr_r[c]   <= ad_s2_r;
            SEL_LSR_EXTRA_FEATURE_CONTROL: extra_feature_control_r[c]  <= ad_s2_r;
            SEL_SPR:      spr_r[c]   <= ad_s2_r;
            SEL_DLL:      dll_r[c]   <= ad_s2_r;
            SEL_DLM:      dlm_r[c]   <= ad_s2_r;
            SEL_EFR:      efr_r[c]   <= ad_s2_r;
            SEL_RESUME_CHAR_1:     resume_char_1_r[c]  <= ad_s2_r;
            SEL_RESUME_CHAR_2:     resume_char_2_r[c]  <= ad_s2_r;
            SEL_PAUSE_CHAR_1:    pause_char_1_r[c] <= ad_s2_r;
            SEL_PAUSE_CHAR_2:    pause_char_2_r[c] <= ad_s2_r;
            SEL_TXLVL:    txlvl_r[c] <= ad_s2_r;
            SEL_RXLVL:    rxlvl_r[c] <= ad_s2_r;
            SEL_FLH:      flh_r[c]   <= ad_s2_r;
            SEL_FLL:      fll_r[c]   <= ad_s2_r;
            SEL_PRESC:    presc_r[c] <= ad_s2_r;
            SEL_TURN:     turn_r[c]  <= ad_s2_r;
            SEL_AF2:      af2_r[c]   <= ad_s2_r;
            SEL_AF1:      af1_r[c]   <= ad_s2_r;
            default:      ;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // mode and queue flush control
  // ************************************************************
  logic [1:0] ext;
  logic [1:0] ext_prev_r;
  logic [1:0] fen_prev_r;
  logic [1:0] flush_rx;
  logic [1:0] flush_tx;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      ext[c] = |{txlvl_r[c], rxlvl_r[c], flh_r[c], fll_r[c]};
      // queues are emptied whenever the extended mode or the enable changes
      flush_rx[c] = (ext[c] != ext_prev_r[c]) | (fcr_r[c][FCR_ENABLE_BIT] != fen_prev_r[c])
                  | (wr_go[c] & wsel[c] == SEL_ISR_FCR & ad_s2_r[FCR_RX_FLUSH_BIT]);
      flush_tx[c] = (ext[c] != ext_prev_r[c]) | (fcr_r[c][FCR_ENABLE_BIT] != fen_prev_r[c])
                  | (wr_go[c] & wsel[c] == SEL_ISR_FCR & ad_s2_r[FCR_TX_FLUSH_BIT]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ext_prev_r <= 2'h0;
      fen_prev_r <= 2'h0;
    end
    else
    begin
      ext_prev_r <= ext;
      fen_prev_r <= {fcr_r[1][FCR_ENABLE_BIT], fcr_r[0][FCR_ENABLE_BIT]};
    end
  end

  assign extended_o       = ext;
  assign line_control_a_o = lcr_r[0];
  assign line_control_b_o = lcr_r[1];

  // ************************************************************
  // queues: q = 2*channel + direction (0 transmit, 1 receive)
  // ************************************************************
  logic [AW-1:0] wp_r [4];
  logic [AW-1:0] rp_r [4];
  logic [7:0]    cnt_r [4];
  logic [3:0]    stale_r;
  logic [3:0]    push;
  logic [3:0]    pop;
  logic [3:0]    flush;
  logic [7:0]    wdat [4];
  logic [7:0]    rdat [4];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      rx_room_o[c] = (cnt_r[2*c+1] != FULL);
      // the memory read lags a pointer move by one cycle, so hold valid back meanwhile
      tx_byte_valid_o[c] = (cnt_r[2*c] != 8'h00) & ~stale_r[2*c];
      push[2*c]   = wr_go[c] & (wsel[c] == SEL_DATA) & (cnt_r[2*c] != FULL);
      pop[2*c]    = tx_byte_take_i[c] & tx_byte_valid_o[c];
      flush[2*c]  = flush_tx[c];
      wdat[2*c]   = ad_s2_r;
      push[2*c+1] = rx_byte_valid_i[c] & rx_room_o[c];
      pop[2*c+1]  = rd_rise & hit_r & (chan_r == 1'(c)) & (rsel[c] == SEL_DATA)
                  & (cnt_r[2*c+1] != 8'h00);
      flush[2*c+1] = flush_rx[c];
    end
    wdat[1] = rx_byte_a_i;
    wdat[3] = rx_byte_b_i;
  end

  for (genvar q = 0; q < 4; q++)
  begin : g_queue
    always_ff @(posedge clk_i)
    begin
      if (srst_i || flush[q])
      begin
        wp_r[q]    <= '0;
        rp_r[q]    <= '0;
        cnt_r[q]   <= 8'h00;
        stale_r[q] <= 1'b0;
      end
      else
      begin
        if (push[q])
        begin
          wp_r[q] <= wp_r[q] + AW'(1);
        end
        if (pop[q])
        begin
          rp_r[q] <= rp_r[q] + AW'(1);
        end
        cnt_r[q]   <= cnt_r[q] + 8'(push[q]) - 8'(pop[q]);
        stale_r[q] <= pop[q] | (push[q] & (cnt_r[q] == 8'h00));
      end
    end

    udr_mem #(.W(8), .D(DEPTH)) u_mem (
      .clk_i   (clk_i),
      .we_i    (push[q]),
      .waddr_i (wp_r[q]),
      .wdata_i (wdat[q]),
      .raddr_i (rp_r[q]),
      .rdata_o (rdat[q])
    );
  end

  assign tx_byte_a_o = rdat[0];
  assign tx_byte_b_o = rdat[2];

  // ************************************************************
  // read path
  // ************************************************************
  logic [7:0] rd_mux;

  always_comb
  begin
    logic [7:0] rc;
    logic [7:0] tc;
    int unsigned c;
    c  = chan_r ? 1 : 0;
    tc = cnt_r[2*c];
    rc = cnt_r[2*c+1];
    case (rsel[c])
      SEL_DATA:     rd_mux = rdat[2*c+1];
      SEL_IER:      rd_mux = ier_r[c];
      SEL_ISR_FCR:  rd_mux = ISR_NO_PENDING | {{2{fcr_r[c][FCR_ENABLE_BIT]}}, 6'h00};
      SEL_LCR:      rd_mux = lcr_r[c];
      SEL_MCR:      rd_mux = mcr_r[c];
      SEL_LSR_EXTRA_FEATURE_CONTROL: rd_mux = {1'b0, tc == 8'h00, tc != FULL, 4'h0, rc != 8'h00};
      SEL_MSR:      rd_mux = 8'h00;
      SEL_SPR:      rd_mux = spr_r[c];
      SEL_DLL:      rd_mux = dll_r[c];
      SEL_DLM:      rd_mux = dlm_r[c];
      SEL_TXCNT:    rd_mux = tc;
      SEL_RXCNT:    rd_mux = rc;
      SEL_EFR:      rd_mux = efr_r[c];
      SEL_RESUME_CHAR_1:     rd_mux = resume_char_1_r[c];
      SEL_RESUME_CHAR_2:     rd_mux = resume_char_2_r[c];
      SEL_PAUSE_CHAR_1:    rd_mux = pause_char_1_r[c];
      SEL_PAUSE_CHAR_2:    rd_mux = pause_char_2_r[c];
      SEL_TXLVL:    rd_mux = txlvl_r[c];
      SEL_RXLVL:    rd_mux = rxlvl_r[c];
      SEL_FLH:      rd_mux = flh_r[c];
      SEL_FLL:      rd_mux = fll_r[c];
      SEL_PRESC:    rd_mux = presc_r[c];
      SEL_TURN:     rd_mux = turn_r[c];
      SEL_AF2:      rd_mux = af2_r[c];
      SEL_AF1:      rd_mux = af1_r[c];
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ad_o    <= 8'h00;
      ad_oe_o <= 1'b0;
    end
    else
    begin
      ad_o    <= rd_mux;
      ad_oe_o <= ~rd_s & ~rd_fall & hit_r & lla_s;
    end
  end

  // ************************************************************
  // queue status pins
  // ************************************************************
  logic [1:0] rx_n;
  logic [1:0] tx_n;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      logic [7:0] trig;
      trig = ext[c] ? rxlvl_r[c] : rx_trigger(fcr_r[c][7:6]);
      if (fcr_r[c][FCR_DMA_BIT])
      begin
        rx_n[c] = (cnt_r[2*c+1] == 8'h00) | (cnt_r[2*c+1] < trig);
      end
      else
      begin
        rx_n[c] = (cnt_r[2*c+1] == 8'h00);
      end
      tx_n[c] = (cnt_r[2*c] == FULL);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rx_avail_n_a_o <= 1'b1;
      rx_avail_n_b_o <= 1'b1;
      tx_space_n_a_o <= 1'b1;
      tx_space_n_b_o <= 1'b1;
    end
    else
    begin
      rx_avail_n_a_o <= rx_n[0];
      rx_avail_n_b_o <= rx_n[1];
      tx_space_n_a_o <= tx_n[0];
      tx_space_n_b_o <= tx_n[1];
    end
  end

  // ************************************************************
  // serial pins
  // ************************************************************
  udr_line u_line_a (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .serial_in_i  (serial_in_a_i),
    .serial_out_o (serial_out_a_o),
    .loop_i       (mcr_r[0][MCR_LOOP_BIT]),
    .tx_off_i     (extra_feature_control_r[0][EXTRA_FEATURE_CONTROL_TX_OFF_BIT]),
    .core_tx_i    (core_tx_i[0]),
    .core_rx_o    (core_rx_o[0])
  );

  udr_line u_line_b (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .serial_in_i  (serial_in_b_i),
    .serial_out_o (serial_out_b_o),
    .loop_i       (mcr_r[1][MCR_LOOP_BIT]),
    .tx_off_i     (extra_feature_control_r[1][EXTRA_FEATURE_CONTROL_TX_OFF_BIT]),
    .core_tx_i    (core_tx_i[1]),
    .core_rx_o    (core_rx_o[1])
  );

endmodule : udr_regs

// *** design/udr_pkg.sv ***
package udr_pkg;

  // ************************************************************
  // register indexes and bank conditions
  // ************************************************************
  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_2 = 3'h2;
  localparam logic [2:0] IDX_3 = 3'h3;
  localparam logic [2:0] IDX_4 = 3'h4;
  localparam logic [2:0] IDX_5 = 3'h5;
  localparam logic [2:0] IDX_6 = 3'h6;
  localparam logic [2:0] IDX_7 = 3'h7;
  localparam logic [7:0] LCR_ENHANCED_KEY = 8'hbf;
  localparam int         LCR_BANK_BIT     = 7;
  localparam int         EXTRA_FEATURE_CONTROL_COUNT_BIT   = 0;
  localparam logic [1:0] EXTRA_FEATURE_CONTROL_BANK_LEVEL  = 2'h1;
  localparam logic [1:0] EXTRA_FEATURE_CONTROL_BANK_PRESC  = 2'h2;
  localparam int         EXTRA_FEATURE_CONTROL_TX_OFF_BIT  = 7;
  localparam int         MCR_LOOP_BIT     = 4;
  localparam int         FCR_ENABLE_BIT   = 0;
  localparam int         FCR_RX_FLUSH_BIT = 1;
  localparam int         FCR_TX_FLUSH_BIT = 2;
  localparam int         FCR_DMA_BIT      = 3;
  localparam int         ADDR_CHAN_BIT    = 6;
  localparam int         ADDR_HIGH_BIT    = 7;

  // ************************************************************
  // reset values and queue shape
  // ************************************************************
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] ISR_NO_PENDING  = 8'h01;
  localparam int         QUEUE_DEPTH     = 128;
  localparam logic [7:0] RX_TRIG_0       = 8'h08;
  localparam logic [7:0] RX_TRIG_1       = 8'h10;
  localparam logic [7:0] RX_TRIG_2       = 8'h18;
  localparam logic [7:0] RX_TRIG_3       = 8'h1c;

  // ************************************************************
  // decoded register target
  // ************************************************************
  typedef enum logic [4:0] {
    SEL_NONE, SEL_DATA, SEL_IER, SEL_ISR_FCR, SEL_LCR, SEL_MCR, SEL_LSR_EXTRA_FEATURE_CONTROL,
    SEL_MSR, SEL_SPR, SEL_DLL, SEL_DLM, SEL_TXCNT, SEL_RXCNT, SEL_EFR,
    SEL_RESUME_CHAR_1, SEL_RESUME_CHAR_2, SEL_PAUSE_CHAR_1, SEL_PAUSE_CHAR_2, SEL_TXLVL, SEL_RXLVL,
    SEL_FLH, SEL_FLL, SEL_PRESC, SEL_TURN, SEL_AF2, SEL_AF1
  } udr_sel_t;

endpackage : udr_pkg

// *** design/udr_mem.sv ***
`timescale 1ns/1ps
module udr_mem #(
  parameter int W = 8,
  parameter int D = 128,
  parameter int A = $clog2(D)
) (
  // clock
  input  wire logic         clk_i,
  // write port
  input  wire logic         we_i,
  input  wire logic [A-1:0] waddr_i,
  input  wire logic [W-1:0] wdata_i,
  // read port, data one cycle after address
  input  wire logic [A-1:0] raddr_i,
  output logic      [W-1:0] rdata_o
);

  logic [W-1:0] mem_r [D];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem_r[raddr_i];
  end

endmodule : udr_mem

// *** design/udr_line.sv ***
`timescale 1ns/1ps
module udr_line (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // serial pins
  input  wire logic serial_in_i,
  output logic      serial_out_o,
  // control
  input  wire logic loop_i,
  input  wire logic tx_off_i,
  // core side
  input  wire logic core_tx_i,
  output logic      core_rx_o
);

  logic in_s1_r;
  logic in_s2_r;

  // ************************************************************
  // pin synchroniser, idle level high
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      in_s1_r <= 1'b1;
      in_s2_r <= 1'b1;
    end
    else
    begin
      in_s1_r <= serial_in_i;
      in_s2_r <= in_s1_r;
    end
  end

  // ************************************************************
  // loopback and output gating
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      core_rx_o <= 1'b1;
    end
    else
    begin
      core_rx_o <= loop_i ? core_tx_i : in_s2_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      serial_out_o <= 1'b1;
    end
    else
    begin
      serial_out_o <= (loop_i | tx_off_i) ? 1'b1 : core_tx_i;
    end
  end

endmodule : udr_line

// *** tb/udr_regs_monitor.sv ***
`timescale 1ns/1ps
// *****
// port checker
// *****
module udr_regs_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic read_strobe_n_i,
  input wire logic serial_in_a_i,
  input wire logic serial_out_a_o,
  input wire logic rx_avail_n_a_o,
  input wire logic tx_space_n_a_o,
  input wire logic ad_oe_o,
  input wire logic [1:0] tx_byte_valid_o,
  input wire logic [1:0] core_tx_i,
  input wire logic [1:0] core_rx_o,
  input wire logic [1:0] extended_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_reset_line_idle: assert property ($fell(srst_i) |-> serial_out_a_o)
    else $error("line low");
  a_reset_rx_empty: assert property ($fell(srst_i) |-> rx_avail_n_a_o)
    else $error("rx ready");
  a_reset_normal_mode: assert property ($fell(srst_i) |-> extended_o == 2'b00)
    else $error("extended");
  a_tx_idle_high: assert property (core_tx_i[0] |=> serial_out_a_o)
    else $error("tx low");
  // pin path has three stages, loop path one
  a_rx_source: assert property (!$past(srst_i, 3) |->
    core_rx_o[0] == $past(core_tx_i[0]) || core_rx_o[0] == $past(serial_in_a_i, 3))
    else $error("rx source");
  a_bus_release: assert property (read_strobe_n_i [*5] |-> !ad_oe_o)
    else $error("bus held");
  a_no_select_quiet: assert property ((cs_n_i && read_strobe_n_i) [*3] ##1
    (cs_n_i && !read_strobe_n_i) [*5] |-> !ad_oe_o)
    else $error("unselected drive");
  a_space_when_empty: assert property (!tx_byte_valid_o[0] [*3] |-> !tx_space_n_a_o)
    else $error("no space");
endmodule : udr_regs_monitor

bind udr_regs udr_regs_monitor u_udr_regs_monitor (
  .clk_i, .srst_i, .cs_n_i, .read_strobe_n_i, .serial_in_a_i, .serial_out_a_o, .rx_avail_n_a_o,
  .tx_space_n_a_o, .ad_oe_o, .tx_byte_valid_o, .core_tx_i, .core_rx_o, .extended_o
);

// *** tb/udr_host_model.sv ***
`timescale 1ns/1ps
// *****
// host bus model
// *****
module udr_host_model (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic oe_i,
  output logic [7:0] ad_o,
  output logic cs_n_o,
  output logic latch_n_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  initial
  begin
    ad_o = 8'h00;
    cs_n_o = 1'b1;
    latch_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic addr_ph(input logic [7:0] a, input logic cs);
    cs_n_o = cs;
    latch_n_o = 1'b0;
    ad_o = a;
    cyc(3);
    latch_n_o = 1'b1;
  endtask : addr_ph
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr_ph(a, 1'b0);
    ad_o = v;
    wr_n_o = 1'b0;
    cyc(5);
    wr_n_o = 1'b1;
    cyc(5);
  endtask : wr
  // released bus shows the inverse, so stale data never passes
  task automatic rd(input logic [7:0] a, input logic cs, output logic [7:0] d, output logic got);
    addr_ph(a, cs);
    ad_o = ~a;
    rd_n_o = 1'b0;
    got = 1'b0;
    d = 8'hxx;
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      if (!got && oe_i === 1'b1)
      begin
        got = 1'b1;
        d = bus_i;
      end
    end
    rd_n_o = 1'b1;
    cyc(5);
  endtask : rd
endmodule : udr_host_model

// *** tb/dual_uart_register_decode_tb_top.sv ***
`timescale 1ns/1ps
// *****
// bench top
// *****
module dual_uart_register_decode_tb_top;
  import udr_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ser = 1'b1;
  logic [1:0] ctx = 2'b11;
  logic [1:0] take = 2'b00;
  logic [1:0] rxv = 2'b00;
  logic [1:0] ext, crx;
  logic [7:0] h_ad, dev_ad, tba, d;
  logic cs_n, ll_n, rd_n, wr_n, oe, got, so_a, rxn_a, txn_a, txn_b;
  logic [2:0] ix [4] = '{IDX_2, IDX_4, IDX_6, IDX_7};
  int n_fail = 0;
  int comparisons = 0;
  wire [7:0] bus = oe ? dev_ad : h_ad;
  initial forever #2.5 clk_i = ~clk_i;
  udr_regs u_udr_regs (
    .clk_i, .srst_i, .ad_i(bus), .ad_o(dev_ad), .ad_oe_o(oe), .cs_n_i(cs_n), .address_latch_n_i(ll_n),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .serial_in_a_i(ser), .serial_in_b_i(ser),
    .serial_out_a_o(so_a), .serial_out_b_o(), .rx_avail_n_a_o(rxn_a), .rx_avail_n_b_o(),
    .tx_space_n_a_o(txn_a), .tx_space_n_b_o(txn_b), .tx_byte_a_o(tba), .tx_byte_b_o(), .tx_byte_valid_o(),
    .tx_byte_take_i(take), .core_tx_i(ctx), .rx_byte_a_i(8'h3c), .rx_byte_b_i(8'h3c),
    .rx_byte_valid_i(rxv), .rx_room_o(), .core_rx_o(crx), .extended_o(ext), .line_control_a_o(),
    .line_control_b_o()
  );
  udr_host_model u_udr_host_model (
    .clk_i, .bus_i(bus), .oe_i(oe), .ad_o(h_ad), .cs_n_o(cs_n), .latch_n_o(ll_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n)
  );
  function automatic logic [7:0] ad(input logic ch, input logic [2:0] i);
    return {1'b0, ch, 2'h0, i, 1'b0};
  endfunction : ad
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic hw(input logic [7:0] a, input logic [7:0] v);
    u_udr_host_model.wr(a, v);
  endtask : hw
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_udr_host_model.rd(a, 1'b0, d, got);
    chk({7'h0, got}, 8'h01);
    if (got !== 1'b1)
      print_verdict();
    else
      chk(d, e);
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  initial
  begin
    tick(2);
    srst_i = 1'b0;
    tick(3);
    chk({4'h0, so_a, rxn_a, ext}, 8'h0c);
    chk({7'h0, txn_a}, 8'h00);
    hw(ad(0, IDX_7), 8'h5a);
    hw(ad(1, IDX_7), 8'ha5);
    hw(ad(0, IDX_7) | 8'h80, 8'hff);
    rdc(ad(0, IDX_7), 8'h5a);
    rdc(ad(1, IDX_7), 8'ha5);
    u_udr_host_model.rd(ad(0, IDX_7), 1'b1, d, got);
    chk({7'h0, got}, 8'h00);
    hw(ad(0, IDX_6), 8'h77);
    rdc(ad(0, IDX_6), 8'h00);
    rdc(ad(0, IDX_2), ISR_NO_PENDING);
    hw(ad(0, IDX_3), 8'h80);
    hw(ad(0, IDX_0), 8'h12);
    hw(ad(0, IDX_1), 8'h34);
    rdc(ad(0, IDX_0), 8'h12);
    rdc(ad(0, IDX_1), 8'h34);
    hw(ad(0, IDX_3), 8'h00);
    rdc(ad(0, IDX_1), 8'h00);
    for (int b = 0; b < 3; b++)
    begin
      if (b == 0)
        hw(ad(0, IDX_3), LCR_ENHANCED_KEY);
      else
        hw(ad(0, IDX_5), 8'(2 * b));
      foreach (ix[i]) hw(ad(0, ix[i]), 8'(16 * b + i + 1));
      foreach (ix[i]) rdc(ad(0, ix[i]), 8'(16 * b + i + 1));
      if (b == 0)
        hw(ad(0, IDX_3), 8'h00);
    end
    chk({6'h0, ext}, 8'h01);
    hw(ad(0, IDX_5), 8'h01);
    for (int i = 0; i < QUEUE_DEPTH; i++) hw(ad(0, IDX_0), 8'(i));
    chk(tba, 8'h00);
    chk({7'h0, txn_a}, 8'h01);
    chk({7'h0, txn_b}, 8'h00);
    rdc(ad(0, IDX_3), 8'(QUEUE_DEPTH));
    hw(ad(0, IDX_4), 8'h55);
    hw(ad(0, IDX_5), 8'h00);
    rdc(ad(0, IDX_4), 8'h00);
    take = 2'b01;
    tick(1);
    take = 2'b00;
    tick(2);
    chk({7'h0, txn_a}, 8'h00);
    chk(tba, 8'h01);
    rxv = 2'b01;
    tick(1);
    rxv = 2'b00;
    tick(2);
    chk({7'h0, rxn_a}, 8'h00);
    rdc(ad(0, IDX_0), 8'h3c);
    tick(2);
    chk({7'h0, rxn_a}, 8'h01);
    hw(ad(0, IDX_2), 8'h08);
    rxv = 2'b01;
    tick(1);
    rxv = 2'b00;
    tick(2);
    chk({7'h0, rxn_a}, 8'h01);
    hw(ad(0, IDX_4), 8'h10);
    ctx = 2'b10;
    tick(4);
    chk({6'h0, so_a, crx[0]}, 8'h02);
    hw(ad(0, IDX_5), 8'h80);
    hw(ad(0, IDX_4), 8'h00);
    chk({7'h0, so_a}, 8'h01);
    print_verdict();
  end
endmodule : dual_uart_register_decode_tb_top
